// ==== src/hp_cp_defs.vh ====
// Register indices, field positions, reset values and codes of the headphone and charge pump bank.
// Assumes byte address = 4 * index on a 32-bit Avalon-MM bus; data sits in bits 7:0.
`ifndef HP_CP_DEFS_VH
`define HP_CP_DEFS_VH

`define IDX_RSVD_1E         8'h1E
`define IDX_LEFT_HP_VOL     8'h1F
`define IDX_RIGHT_HP_VOL    8'h20
`define IDX_CP_CLOCK        8'h21
`define IDX_CP_CONFIG       8'h22
`define IDX_CP_POWER        8'h23
`define IDX_RECV_POS_VOL    8'h24
`define IDX_STATUS          8'h30

`define RST_RSVD_1E         8'h00
`define RST_LEFT_HP_VOL     8'hB9
`define RST_RIGHT_HP_VOL    8'hB9
`define RST_CP_CLOCK        8'h28
`define RST_CP_CONFIG       8'h3E
`define RST_CP_POWER        8'h10
`define RST_RECV_POS_VOL    8'h7F

// Writable bits per register; the rest read back their reset value
`define WMASK_HP_VOL        8'hBF
`define WMASK_CP_CLOCK      8'hFF
`define WMASK_CP_CONFIG     8'hFF
`define WMASK_CP_POWER      8'h23
`define WMASK_RECV_POS_VOL  8'h7F

`define BIT_TOPOLOGY        7
`define BIT_LINK_RIGHT      7
`define VOL_MSB             5
`define VOL_LSB             0
`define VOL_MUTE            6'h39
`define DIV_MSB             4
`define DIV_LSB             1
`define DIV_ZERO_RATIO      5'h10
`define CM_MSB              7
`define CM_LSB              6
`define PWR_SCALE_MSB       4
`define PWR_SCALE_LSB       2
`define DCOC_MSB            1
`define DCOC_LSB            0
`define BIT_DYN_CAL         5
`define CP_MODE_MSB         1
`define CP_MODE_LSB         0
`define CP_MODE_AUTO        2'h0
`define CP_MODE_ON          2'h1
`define CP_MODE_OFF         2'h2
`define RECV_MSB            6
`define RECV_LSB            0
`define RECV_DISCONNECT     7'h7F

`endif

// ==== src/headphone_chargepump_regs.v ====
// Headphone driver and charge pump configuration bank with an Avalon-MM slave.
// Assumes a master that holds each request until it sees waitrequest low.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "hp_cp_defs.vh"

module headphone_chargepump_regs (
    input  wire        clk,                 // 250 MHz clock
    input  wire        arst_n,              // Asynchronous reset, active low
    input  wire [7:0]  address,             // Avalon byte address
    input  wire        read,                // Avalon read request
    input  wire        write,               // Avalon write request
    input  wire [3:0]  byteenable,          // Avalon byte enables
    input  wire [31:0] writedata,           // Avalon write data
    output reg  [31:0] readdata,            // Avalon read data
    output reg         waitrequest,         // Avalon wait, high until answer
    input  wire        hp_power_up,         // Ground-centered headphone powered up
    output reg         ground_centered,     // Headphone topology is ground-centered
    output reg  [5:0]  left_volume_field,   // Gain code to left headphone driver
    output reg  [5:0]  right_volume_field,  // Effective gain code to right driver
    output reg         left_muted,          // Left driver volume muted
    output reg         right_muted,         // Right driver volume muted
    output reg  [4:0]  cp_div_ratio,        // Pump clock divide ratio, 1..16
    output reg         cp_clk_en,           // Pump clock enable pulse
    output reg  [1:0]  common_mode_sel,     // Output common-mode reference
    output reg  [3:0]  cp_current_eighths,  // Pump capability in eighths of peak
    output reg  [1:0]  dc_offset_mode,      // DC offset correction mode
    output reg         dyn_cal_en,          // Dynamic offset calibration enable
    output reg         cp_running,          // Charge pump powered
    output reg  [6:0]  receiver_atten,      // Line output to receiver attenuation
    output reg         receiver_disconnect  // Line output not routed to receiver
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and bus decode

    reg  [7:0]  left_hp_vol;
    reg  [7:0]  right_hp_vol;
    reg  [7:0]  cp_clock;
    reg  [7:0]  cp_config;
    reg  [7:0]  cp_power;
    reg  [7:0]  recv_pos_vol;
    reg  [3:0]  div_count;
    reg  [7:0]  next_read_byte;
    wire [5:0]  word_index;
    wire        aligned;
    wire        wr_take;
    wire        wr_lane;
    wire [7:0]  wbyte;
    wire [7:0]  index8;
    wire [1:0]  mode_now;
    wire [4:0]  ratio_now;
    wire        pump_on_now;

    assign word_index = address[7:2];
    assign aligned    = (address[1:0] == 2'h0);
    assign index8     = {2'h0, word_index};
    // Write lands only at the edge where waitrequest is seen low
    assign wr_take    = write && !read && !waitrequest && aligned;
    assign wr_lane    = wr_take && byteenable[0];
    assign wbyte      = writedata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then one answer cycle

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end else begin
            if ((read || write) && waitrequest) begin
                waitrequest <= 1'b0;
                readdata    <= {24'h000000, next_read_byte};
            end else begin
                waitrequest <= 1'b1;
            end
        end
    end

    // Unmapped or misaligned reads return zero; reserved bits read fixed
    always @* begin
        next_read_byte = 8'h00;
        if (aligned) begin
            case (index8)
                `IDX_RSVD_1E:      next_read_byte = `RST_RSVD_1E;
                `IDX_LEFT_HP_VOL:  next_read_byte = left_hp_vol;
                `IDX_RIGHT_HP_VOL: next_read_byte = right_hp_vol;
                `IDX_CP_CLOCK:     next_read_byte = cp_clock;
                `IDX_CP_CONFIG:    next_read_byte = cp_config;
                `IDX_CP_POWER:     next_read_byte = cp_power;
                `IDX_RECV_POS_VOL: next_read_byte = recv_pos_vol;
                `IDX_STATUS:       next_read_byte = {7'h00, cp_running};
                default:           next_read_byte = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; read-only bits keep their reset value

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left_hp_vol  <= `RST_LEFT_HP_VOL;
            right_hp_vol <= `RST_RIGHT_HP_VOL;
            cp_clock     <= `RST_CP_CLOCK;
            cp_config    <= `RST_CP_CONFIG;
            cp_power     <= `RST_CP_POWER;
            recv_pos_vol <= `RST_RECV_POS_VOL;
        end else if (wr_lane) begin
            case (index8)
                `IDX_LEFT_HP_VOL:
                    left_hp_vol <= (wbyte & `WMASK_HP_VOL)
                                 | (`RST_LEFT_HP_VOL & ~`WMASK_HP_VOL);
                `IDX_RIGHT_HP_VOL:
                    right_hp_vol <= (wbyte & `WMASK_HP_VOL)
                                  | (`RST_RIGHT_HP_VOL & ~`WMASK_HP_VOL);
                `IDX_CP_CLOCK:
                    cp_clock <= wbyte & `WMASK_CP_CLOCK;
                `IDX_CP_CONFIG:
                    cp_config <= wbyte & `WMASK_CP_CONFIG;
                `IDX_CP_POWER:
                    cp_power <= (wbyte & `WMASK_CP_POWER)
                              | (`RST_CP_POWER & ~`WMASK_CP_POWER);
                `IDX_RECV_POS_VOL:
                    recv_pos_vol <= (wbyte & `WMASK_RECV_POS_VOL)
                                  | (`RST_RECV_POS_VOL & ~`WMASK_RECV_POS_VOL);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charge pump clock divider and power

    // Code zero stands for the largest ratio
    assign ratio_now = (cp_clock[`DIV_MSB:`DIV_LSB] == 4'h0) ? `DIV_ZERO_RATIO
                     : {1'b0, cp_clock[`DIV_MSB:`DIV_LSB]};
    assign mode_now  = cp_power[`CP_MODE_MSB:`CP_MODE_LSB];
    // Reserved mode 11 treated as off, the safe side for the supply
    assign pump_on_now = (mode_now == `CP_MODE_ON)
                      || ((mode_now == `CP_MODE_AUTO) && hp_power_up);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= 4'h0;
            cp_clk_en <= 1'b0;
        end else begin
            // Counter runs 0..ratio-1; a ratio change restarts cleanly at wrap
            if ({1'b0, div_count} >= (ratio_now - 5'h01)) begin
                div_count <= 4'h0;
                cp_clk_en <= pump_on_now;
            end else begin
                div_count <= div_count + 4'h1;
                cp_clk_en <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls, registered so every output comes from a flip-flop

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ground_centered     <= 1'b1;
            left_volume_field   <= `VOL_MUTE;
            right_volume_field  <= `VOL_MUTE;
            left_muted          <= 1'b1;
            right_muted         <= 1'b1;
            cp_div_ratio        <= 5'h04;
            common_mode_sel     <= 2'h0;
            cp_current_eighths  <= 4'h8;
            dc_offset_mode      <= 2'h2;
            dyn_cal_en          <= 1'b0;
            cp_running          <= 1'b0;
            receiver_atten      <= `RECV_DISCONNECT;
            receiver_disconnect <= 1'b1;
        end else begin
            ground_centered <= left_hp_vol[`BIT_TOPOLOGY];
            left_volume_field <= left_hp_vol[`VOL_MSB:`VOL_LSB];
            left_muted <= (left_hp_vol[`VOL_MSB:`VOL_LSB] == `VOL_MUTE);
            if (right_hp_vol[`BIT_LINK_RIGHT]) begin
                right_volume_field <= left_hp_vol[`VOL_MSB:`VOL_LSB];
                right_muted <= (left_hp_vol[`VOL_MSB:`VOL_LSB] == `VOL_MUTE);
            end else begin
                right_volume_field <= right_hp_vol[`VOL_MSB:`VOL_LSB];
                right_muted <= (right_hp_vol[`VOL_MSB:`VOL_LSB] == `VOL_MUTE);
            end
            cp_div_ratio <= ratio_now;
            common_mode_sel <= cp_config[`CM_MSB:`CM_LSB];
            cp_current_eighths <= {1'b0, cp_config[`PWR_SCALE_MSB:`PWR_SCALE_LSB]}
                                + 4'h1;
            dc_offset_mode <= cp_config[`DCOC_MSB:`DCOC_LSB];
            dyn_cal_en <= cp_power[`BIT_DYN_CAL];
            cp_running <= pump_on_now;
            receiver_atten <= recv_pos_vol[`RECV_MSB:`RECV_LSB];
            receiver_disconnect <=
                (recv_pos_vol[`RECV_MSB:`RECV_LSB] == `RECV_DISCONNECT);
        end
    end

endmodule // headphone_chargepump_regs

// ==== test/hp_cp_regs_sva.sv ====
// Checker for the headphone and charge pump register bank.
// Assumes it is bound to the bank's top module ports.
`timescale 1ns/1ns
module hp_cp_regs_chk (
    input wire        clk,                // Clock
    input wire        arst_n,             // Reset, active low
    input wire        read,               // Bus read
    input wire        write,              // Bus write
    input wire [31:0] readdata,           // Bus read data
    input wire        waitrequest,        // Bus wait
    input wire [5:0]  left_volume_field,  // Left gain code
    input wire [5:0]  right_volume_field, // Right gain code
    input wire        left_muted,         // Left mute
    input wire        right_muted,        // Right mute
    input wire [4:0]  cp_div_ratio,       // Pump divide ratio
    input wire [3:0]  cp_current_eighths, // Pump capability
    input wire [6:0]  receiver_atten,     // Receiver attenuation
    input wire        receiver_disconnect // Receiver unrouted
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_taken; (read || write) && waitrequest; endsequence
    sequence s_answer; !waitrequest ##1 waitrequest; endsequence
    property p_answer; s_taken |=> s_answer; endproperty
    property p_no_spurious; !waitrequest |-> $past(read || write); endproperty
    property p_upper; !waitrequest |-> readdata[31:8] == 24'h000000; endproperty
    property p_lmute; left_muted == (left_volume_field == 6'h39); endproperty
    property p_rmute; right_muted == (right_volume_field == 6'h39); endproperty
    property p_disc; receiver_disconnect == (receiver_atten == 7'h7F); endproperty
    property p_ratio; cp_div_ratio >= 5'h01 && cp_div_ratio <= 5'h10; endproperty
    property p_eighths; cp_current_eighths >= 4'h1 && cp_current_eighths <= 4'h8; endproperty
    a_answer: assert property (p_answer) else $error("no single wait pulse");
    a_no_spurious: assert property (p_no_spurious) else $error("unasked answer");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_lmute: assert property (p_lmute) else $error("left mute wrong");
    a_rmute: assert property (p_rmute) else $error("right mute wrong");
    a_disc: assert property (p_disc) else $error("disconnect wrong");
    a_ratio: assert property (p_ratio) else $error("ratio out of range");
    a_eighths: assert property (p_eighths) else $error("capability out of range");
endmodule // hp_cp_regs_chk

bind headphone_chargepump_regs hp_cp_regs_chk hp_cp_regs_chk_inst (.clk(clk),
    .arst_n(arst_n), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .left_volume_field(left_volume_field),
    .right_volume_field(right_volume_field), .left_muted(left_muted),
    .right_muted(right_muted), .cp_div_ratio(cp_div_ratio),
    .cp_current_eighths(cp_current_eighths), .receiver_atten(receiver_atten),
    .receiver_disconnect(receiver_disconnect));

// ==== test/tb_top.sv ====
// Self-checking bench for the headphone and charge pump register bank.
// Assumes byte address 4 * index and a one-cycle wait per request.
`timescale 1ns/1ns
module tb_top;
    logic        clk = 0, arst_n = 0, read = 0, write = 0, hp_power_up = 0;
    logic [7:0]  address = 8'h00;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata;
    logic        waitrequest, ground_centered, left_muted, right_muted, cp_clk_en;
    logic        dyn_cal_en, cp_running, receiver_disconnect;
    logic [5:0]  left_volume_field, right_volume_field;
    logic [4:0]  cp_div_ratio;
    logic [3:0]  cp_current_eighths;
    logic [1:0]  common_mode_sel, dc_offset_mode;
    logic [6:0]  receiver_atten;
    logic [7:0]  m [0:6];
    logic [7:0]  rst [0:6] = '{8'h00, 8'hB9, 8'hB9, 8'h28, 8'h3E, 8'h10, 8'h7F};
    logic [7:0]  msk [0:6] = '{8'h00, 8'hBF, 8'hBF, 8'hFF, 8'hFF, 8'h23, 8'h7F};
    logic [7:0]  rsv [0:6] = '{8'hFF, 8'h40, 8'h40, 8'hE1, 8'h20, 8'hDC, 8'h80};
    integer      n_errors = 0, checked = 0, seed = 32'h67FE, i, t;

    headphone_chargepump_regs headphone_chargepump_regs_inst (.clk(clk), .arst_n(arst_n),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .hp_power_up(hp_power_up), .ground_centered(ground_centered),
        .left_volume_field(left_volume_field), .right_volume_field(right_volume_field),
        .left_muted(left_muted), .right_muted(right_muted), .cp_div_ratio(cp_div_ratio),
        .cp_clk_en(cp_clk_en), .common_mode_sel(common_mode_sel),
        .cp_current_eighths(cp_current_eighths), .dc_offset_mode(dc_offset_mode),
        .dyn_cal_en(dyn_cal_en), .cp_running(cp_running), .receiver_atten(receiver_atten),
        .receiver_disconnect(receiver_disconnect));

    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input [31:0] seen, input [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Host side: random data shaped into what software may legally write
    function automatic [7:0] legal(input integer r, input [7:0] x);
        integer k;
        legal = x & ~rsv[r] | rst[r] & rsv[r];
        k = {$random(seed)} % 22;
        if (r == 1 || r == 2) legal[5:0] = k == 21 ? 6'h39 : 6'(k < 6 ? 58 + k : k - 6);
        if (r == 1 && !m[2][7]) legal[7] = 1'b0;
        if (r == 2 && m[1][7]) legal[7] = 1'b1;
        if (r == 4 && legal[7:6] == 2'h3) legal[7:6] = 2'h2;
        if (r == 4 && legal[1:0] == 2'h1) legal[1:0] = 2'h3;
        if (r == 5 && legal[1:0] == 2'h3) legal[1:0] = 2'h2;
        if (r == 6 && legal[6:0] >= 7'h76 && legal[6:0] < 7'h7F) legal[6:0] = 7'h7F;
    endfunction

    function automatic [31:0] pump_on;
        pump_on = m[5][1:0] == 2'h1 || (m[5][1:0] == 2'h0 && hp_power_up);
    endfunction

    // Request held until waitrequest is seen low; data taken at that edge
    task automatic acc(input bit wr, input [7:0] a, input [7:0] d, input bit be);
        integer r;
        r = a / 4 - 30;
        if (a[1:0] != 2'h0 || r < 0 || r > 6) r = 7;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        byteenable <= {3'b101, be};
        writedata <= ($random(seed) & 32'hFFFFFF00) | d;
        t = 0;
        do begin @(posedge clk); t++; end while (waitrequest !== 1'b0 && t < 50);
        if (t >= 50) n_errors++;
        if (!wr) chk(readdata, r < 7 ? m[r] : (a == 8'hC0 ? pump_on() : 0));
        read <= 0;
        write <= 0;
        if (wr && be && r < 7) m[r] = m[r] & ~msk[r] | d & msk[r];
    endtask

    task automatic check_out;
        logic [5:0] rv;
        rv = m[2][7] ? m[1][5:0] : m[2][5:0];
        repeat (2) @(posedge clk);
        #1;
        chk(ground_centered, m[1][7]);
        chk(left_volume_field, m[1][5:0]);
        chk(left_muted, m[1][5:0] == 6'h39);
        chk(right_volume_field, rv);
        chk(right_muted, rv == 6'h39);
        chk(cp_div_ratio, m[3][4:1] == 0 ? 16 : m[3][4:1]);
        chk(common_mode_sel, m[4][7:6]);
        chk(cp_current_eighths, m[4][4:2] + 1);
        chk(dc_offset_mode, m[4][1:0]);
        chk(dyn_cal_en, m[5][5]);
        chk(cp_running, pump_on());
        chk(receiver_atten, m[6][6:0]);
        chk(receiver_disconnect, m[6][6:0] == 7'h7F);
    endtask

    // Pump forced on; edges between two enable pulses must equal the ratio
    task automatic period(input [3:0] c, input integer ratio);
        acc(1, 8'h84, {3'b001, c, 1'b0}, 1);
        repeat (40) @(posedge clk);
        for (t = 0; t < 40 && cp_clk_en !== 1'b1; t++) @(posedge clk);
        for (t = 1; t < 40; t++) begin
            @(posedge clk);
            if (cp_clk_en === 1'b1) break;
        end
        chk(t, ratio);
    endtask

    task automatic finish_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        finish_test;
    end

    initial begin
        m = rst;
        repeat (12) @(posedge clk);
        arst_n <= 1;
        check_out;
        for (i = 8'h74; i <= 8'hC4; i += 4) acc(0, i, 0, 1);
        acc(0, 8'h7D, 0, 1);
        acc(1, 8'h7C, 8'h39, 1);
        acc(1, 8'h80, 8'h05, 1);
        check_out;
        acc(1, 8'h8C, 8'h30, 1);
        check_out;
        for (i = 0; i < 80; i++) begin
            hp_power_up <= $random(seed);
            t = 8'h78 + 4 * ({$random(seed)} % 8);
            acc(1, t, t < 8'h94 ? legal(t / 4 - 30, $random(seed)) : $random(seed),
                {$random(seed)} % 4 != 0);
            check_out;
            acc(0, 8'h78 + 4 * ({$random(seed)} % 8), 0, 1);
        end
        acc(1, 8'h8C, 8'h01, 1);
        period(4'h1, 1);
        period(4'h3, 3);
        period(4'h0, 16);
        acc(0, 8'hC0, 0, 1);
        acc(1, 8'h8C, 8'h02, 1);
        repeat (4) @(posedge clk);
        t = 0;
        repeat (40) @(posedge clk) if (cp_clk_en === 1'b1) t++;
        chk(t, 0);
        arst_n <= 0;
        repeat (2) @(posedge clk);
        arst_n <= 1;
        m = rst;
        check_out;
        finish_test;
    end
endmodule // tb_top
